// ---- rtl/irq_ctrl_defs.vh ----
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
// Register byte addresses on the Avalon-MM slave (word aligned).
`define ADDR_EDGE_SEL     5'h00
`define ADDR_CTRL0        5'h04
`define ADDR_CTRL1        5'h08
`define ADDR_CTRL2        5'h0c
`define ADDR_GRP0         5'h10
`define ADDR_GRP1         5'h14
`define ADDR_STATUS       5'h18
// Field positions.
`define C0_GLOBAL_EN      0
`define C0_EXT_EN         1
`define C0_TB0_EN         2
`define C0_TB1_EN         3
`define C0_EXT_F          4
`define C0_TB0_F          5
`define C0_TB1_F          6
`define C1_G0_EN          0
`define C1_G1_EN          1
`define C1_OV_EN          2
`define C1_UV_EN          3
`define C1_G0_F           4
`define C1_G1_F           5
`define C1_OV_F           6
`define C1_UV_F           7
`define C2_SINE_EN        0
`define C2_SINE_F         4
`define G_PER_EN          0
`define G_CMPA_EN         1
`define G_PER_F           4
`define G_CMPA_F          5
// Edge select encodings.
`define EDGE_NONE         2'h0
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3
// Source indices in priority order, 0 is most urgent.
`define SRC_EXT           3'h0
`define SRC_TB0           3'h1
`define SRC_TB1           3'h2
`define SRC_OV            3'h3
`define SRC_UV            3'h4
`define SRC_SINE          3'h5
`define SRC_GRP0          3'h6
`define SRC_GRP1          3'h7
`define NUM_SRC           8
`define RESET_BYTE        8'h00
`endif

// ---- rtl/irq_ctrl.v ----
// Operation
// - Edge select 00 off, 01 rising, 10 falling, 11 both edges set external flag.
// - A source's trigger sets its flag whatever its enable bit.
// - A set flag causes a vector jump only when its enable is one.
// - Global enable at zero suppresses every interrupt.
// - On entry the next address is pushed and vector loaded into program counter.
// - Handlers end with return, which pops the saved program counter.
// - Entering service clears the global enable, preventing nesting.
// - Requests during disabled periods still set and hold their flags.
// - No request is acknowledged while the stack is full.
// - A newly set flag wakes the device from sleep or idle.
// - Six sources have own vectors; timer sources share one vector per group.
// - Control register 0 bit layout: global, ext, tb0, tb1 enables, then flags.
// - Control register 1 bit layout: group, over, under enables then flags.
// - Control register 2 holds sine enable bit 0, flag bit 4, rest zero.
// - Group 0 register: period enable 0, compare enable 1, flags 4 and 5.
// - Group 1 register: same layout for the compact timer.
// - Servicing an own-vector source clears its flag and the global enable.
// - Group flag sets on any enabled member event, clears on service or a software write.
// - Sine flag sets on every sine generator edge event.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "irq_ctrl_defs.vh"
module irq_ctrl #(
   parameter        PC_W    = 12,
   parameter [11:0] VEC_EXT  = 12'h004,
   parameter [11:0] VEC_TB0  = 12'h008,
   parameter [11:0] VEC_TB1  = 12'h00c,
   parameter [11:0] VEC_OV   = 12'h010,
   parameter [11:0] VEC_UV   = 12'h014,
   parameter [11:0] VEC_SINE = 12'h018,
   parameter [11:0] VEC_GRP0 = 12'h01c,
   parameter [11:0] VEC_GRP1 = 12'h020
) (
   input  wire             CORE_CLK,
   input  wire             RSTN,
   input  wire [4:0]       AVS_ADDRESS,
   input  wire             AVS_READ,
   input  wire             AVS_WRITE,
   input  wire [31:0]      AVS_WRITEDATA,
   input  wire [3:0]       AVS_BYTEENABLE,
   output reg  [31:0]      AVS_READDATA,
   output wire             AVS_WAITREQUEST,
   input  wire             EXT_PIN,
   input  wire             TIMEBASE0_TICK,
   input  wire             TIMEBASE1_TICK,
   input  wire             OVERVOLTAGE_EVENT,
   input  wire             UNDERVOLTAGE_EVENT,
   input  wire             SINE_EDGE_EVENT,
   input  wire             STD_PERIOD_MATCH,
   input  wire             STD_COMPARE_A_MATCH,
   input  wire             COMPACT_PERIOD_MATCH,
   input  wire             COMPACT_COMPARE_A_MATCH,
   input  wire             STACK_FULL,
   input  wire             TAKE_READY,
   input  wire [PC_W-1:0]  NEXT_PC,
   output reg              IRQ_TAKE,
   output reg  [PC_W-1:0]  IRQ_VECTOR,
   output reg  [PC_W-1:0]  PUSH_PC,
   output reg              WAKEUP
);
   reg  [1:0]  edge_sel_reg;
   reg  [6:0]  ctrl0_reg;
   reg  [7:0]  ctrl1_reg;
   reg         sine_en_reg;
   reg         sine_f_reg;
   reg  [1:0]  grp0_en_reg;
   reg  [1:0]  grp0_f_reg;
   reg  [1:0]  grp1_en_reg;
   reg  [1:0]  grp1_f_reg;
   reg         pin_meta_reg;
   reg         pin_sync_reg;
   reg         pin_prev_reg;
   reg         ack_pend_reg;
   reg  [6:0]  ctrl0_next;
   reg  [7:0]  ctrl1_next;
   reg         sine_f_next;
   reg  [1:0]  grp0_f_next;
   reg  [1:0]  grp1_f_next;
   reg  [2:0]  sel_src;
   reg         sel_valid;
   reg  [11:0] sel_vec;
   reg  [31:0] rd_data;
   wire [7:0]  req;
   wire        rise;
   wire        fall;
   wire        ext_hit;
   wire        grp0_hit;
   wire        grp1_hit;
   wire        take;
   wire        wr_lo;
   wire        flag_new;
   integer     i;

   // Overview of the request path.
   // Each source raises its own flag from a one-cycle event pulse.
   // The external pin is the only source from outside the clock domain.
   // It passes two flip-flops before the edge detector reads it.
   // A third flip-flop holds the previous synchronised level for edge detection.
   // The previous level resets low, matching the idle level of the pin.
   // A pin that idles high would show one false rising edge after reset.
   // Software must therefore select the edge only after the pin has settled.
   // Flags are plain read-write bits, so software may raise or clear them.
   // A flag only asks for service when its own enable bit is also set.
   // The global enable then gates every request at once.
   // Requests are ranked by a fixed order, lowest source index first.
   // The core signals whether it can accept an interrupt in this cycle.
   // The core also reports a full stack, which holds every request back.
   // On acceptance the global enable and the serviced flag are cleared.
   // Group flags clear on service, but their member flags stay set.
   // Software has to clear the member flags by writing zero to them.
   // Otherwise a later event of a disabled member would not raise a fresh wake-up.
   // The take pulse, vector and return address leave on the same edge.
   // They are registered so the core sees clean, glitch-free values.
   // This costs one cycle of latency between request and take.
   // Register reads are also registered, which adds one wait state.
   // Every bus access therefore takes exactly two cycles.
   // The upper byte lanes are ignored on write and read back as zero.

   // Every access completes in two cycles; the wait lets read data come from a flop.
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_pend_reg;
   assign wr_lo = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];

   assign rise = pin_sync_reg & ~pin_prev_reg;
   assign fall = ~pin_sync_reg & pin_prev_reg;
   assign ext_hit = (edge_sel_reg == `EDGE_RISE & rise) | (edge_sel_reg == `EDGE_FALL & fall) |
                    (edge_sel_reg == `EDGE_BOTH & (rise | fall));
   // Group flags are set by the enabled member events, not by the member flags.
   assign grp0_hit = (STD_PERIOD_MATCH & grp0_en_reg[`G_PER_EN]) |
                     (STD_COMPARE_A_MATCH & grp0_en_reg[`G_CMPA_EN]);
   assign grp1_hit = (COMPACT_PERIOD_MATCH & grp1_en_reg[`G_PER_EN]) |
                     (COMPACT_COMPARE_A_MATCH & grp1_en_reg[`G_CMPA_EN]);

   assign req[`SRC_EXT]  = ctrl0_reg[`C0_EXT_F] & ctrl0_reg[`C0_EXT_EN];
   assign req[`SRC_TB0]  = ctrl0_reg[`C0_TB0_F] & ctrl0_reg[`C0_TB0_EN];
   assign req[`SRC_TB1]  = ctrl0_reg[`C0_TB1_F] & ctrl0_reg[`C0_TB1_EN];
   assign req[`SRC_OV]   = ctrl1_reg[`C1_OV_F] & ctrl1_reg[`C1_OV_EN];
   assign req[`SRC_UV]   = ctrl1_reg[`C1_UV_F] & ctrl1_reg[`C1_UV_EN];
   assign req[`SRC_SINE] = sine_f_reg & sine_en_reg;
   assign req[`SRC_GRP0] = ctrl1_reg[`C1_G0_F] & ctrl1_reg[`C1_G0_EN];
   assign req[`SRC_GRP1] = ctrl1_reg[`C1_G1_F] & ctrl1_reg[`C1_G1_EN];

   // Lowest index wins, giving a fixed order among simultaneous requests.
   always @* begin
      // With nothing pending the status register reads back as all zero.
      sel_src = `SRC_EXT;
      sel_valid = 1'b0;
      for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            sel_src = i[2:0];
            sel_valid = 1'b1;
         end
      end
   end

   always @* begin
      case (sel_src)
         `SRC_EXT:  sel_vec = VEC_EXT;
         `SRC_TB0:  sel_vec = VEC_TB0;
         `SRC_TB1:  sel_vec = VEC_TB1;
         `SRC_OV:   sel_vec = VEC_OV;
         `SRC_UV:   sel_vec = VEC_UV;
         `SRC_SINE: sel_vec = VEC_SINE;
         `SRC_GRP0: sel_vec = VEC_GRP0;
         default:   sel_vec = VEC_GRP1;
      endcase
   end

   // Acceptance waits for the core to be ready and for room on the stack.
   assign take = sel_valid & ctrl0_reg[`C0_GLOBAL_EN] & ~STACK_FULL & TAKE_READY;

   // Flag update order: software write, then service clear, then hardware set wins last.
   // The order matters when several causes meet in one cycle.
   // A write that clears a flag must not hide an event of the same cycle.
   // Otherwise that request would be lost without trace.
   // A service clear is likewise overridden by a new event of the same source.
   // The source is then serviced a second time, which is the safer outcome.
   // A write to the first control register also rewrites the global enable.
   // Software uses this to allow nesting from inside a handler.
   // The service clear of the global enable still wins over such a write.
   // This keeps the clear on entry reliable, whatever software does.
   // Group member flags never clear on service, only by software writes.
   always @* begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      sine_f_next = sine_f_reg;
      grp0_f_next = grp0_f_reg;
      grp1_f_next = grp1_f_reg;
      if (wr_lo) begin
         case (AVS_ADDRESS)
            `ADDR_CTRL0: ctrl0_next = AVS_WRITEDATA[6:0];
            `ADDR_CTRL1: ctrl1_next = AVS_WRITEDATA[7:0];
            `ADDR_CTRL2: sine_f_next = AVS_WRITEDATA[`C2_SINE_F];
            `ADDR_GRP0:  grp0_f_next = {AVS_WRITEDATA[`G_CMPA_F], AVS_WRITEDATA[`G_PER_F]};
            `ADDR_GRP1:  grp1_f_next = {AVS_WRITEDATA[`G_CMPA_F], AVS_WRITEDATA[`G_PER_F]};
            default: ;
         endcase
      end
      if (take) begin
         ctrl0_next[`C0_GLOBAL_EN] = 1'b0;
         case (sel_src)
            `SRC_EXT:  ctrl0_next[`C0_EXT_F] = 1'b0;
            `SRC_TB0:  ctrl0_next[`C0_TB0_F] = 1'b0;
            `SRC_TB1:  ctrl0_next[`C0_TB1_F] = 1'b0;
            `SRC_OV:   ctrl1_next[`C1_OV_F] = 1'b0;
            `SRC_UV:   ctrl1_next[`C1_UV_F] = 1'b0;
            `SRC_SINE: sine_f_next = 1'b0;
            `SRC_GRP0: ctrl1_next[`C1_G0_F] = 1'b0;
            default:   ctrl1_next[`C1_G1_F] = 1'b0;
         endcase
      end
      // Hardware events set flags regardless of the source enables; group flags only from enabled members.
      if (ext_hit)             ctrl0_next[`C0_EXT_F] = 1'b1;
      if (TIMEBASE0_TICK)      ctrl0_next[`C0_TB0_F] = 1'b1;
      if (TIMEBASE1_TICK)      ctrl0_next[`C0_TB1_F] = 1'b1;
      if (OVERVOLTAGE_EVENT)   ctrl1_next[`C1_OV_F] = 1'b1;
      if (UNDERVOLTAGE_EVENT)  ctrl1_next[`C1_UV_F] = 1'b1;
      if (SINE_EDGE_EVENT)     sine_f_next = 1'b1;
      if (grp0_hit)            ctrl1_next[`C1_G0_F] = 1'b1;
      if (grp1_hit)            ctrl1_next[`C1_G1_F] = 1'b1;
      if (STD_PERIOD_MATCH)        grp0_f_next[0] = 1'b1;
      if (STD_COMPARE_A_MATCH)     grp0_f_next[1] = 1'b1;
      if (COMPACT_PERIOD_MATCH)    grp1_f_next[0] = 1'b1;
      if (COMPACT_COMPARE_A_MATCH) grp1_f_next[1] = 1'b1;
   end

   // A wake-up is any flag going from clear to set; one already set gives none.
   assign flag_new = (|(ctrl0_next[6:4] & ~ctrl0_reg[6:4])) | (|(ctrl1_next[7:4] & ~ctrl1_reg[7:4])) |
                     (sine_f_next & ~sine_f_reg) | (|(grp0_f_next & ~grp0_f_reg)) |
                     (|(grp1_f_next & ~grp1_f_reg));

   // Read multiplexer for the register bus.
   // Unused bits and unmapped addresses read as zero.
   // The status word shows the source that would be taken next.
   // It is meant for debugging and has no side effect on read.
   // Reading a flag never clears it; only writes and service do.
   always @* begin
      rd_data = 32'h00000000;
      case (AVS_ADDRESS)
         `ADDR_EDGE_SEL: rd_data[1:0] = edge_sel_reg;
         `ADDR_CTRL0:    rd_data[6:0] = ctrl0_reg;
         `ADDR_CTRL1:    rd_data[7:0] = ctrl1_reg;
         `ADDR_CTRL2: begin
            rd_data[`C2_SINE_EN] = sine_en_reg;
            rd_data[`C2_SINE_F]  = sine_f_reg;
         end
         `ADDR_GRP0: begin
            rd_data[`G_PER_EN]  = grp0_en_reg[0];
            rd_data[`G_CMPA_EN] = grp0_en_reg[1];
            rd_data[`G_PER_F]   = grp0_f_reg[0];
            rd_data[`G_CMPA_F]  = grp0_f_reg[1];
         end
         `ADDR_GRP1: begin
            rd_data[`G_PER_EN]  = grp1_en_reg[0];
            rd_data[`G_CMPA_EN] = grp1_en_reg[1];
            rd_data[`G_PER_F]   = grp1_f_reg[0];
            rd_data[`G_CMPA_F]  = grp1_f_reg[1];
         end
         `ADDR_STATUS: rd_data[3:0] = {sel_valid, sel_src};
         default: ;
      endcase
   end

   // All state sits in one clocked process with an asynchronous reset.
   // Reset clears every register, so no source is enabled after reset.
   // The edge select resets to none, so the pin raises nothing at first.
   // The wait-state flop toggles for each request cycle.
   // It drops waitrequest in the second cycle of every access.
   // A write lands on the same edge that the master sees waitrequest low.
   // Read data is captured in the first cycle and stands until the next read.
   // The enable bits of control register 2 and the group registers are written directly.
   // Their flags go through the next-state logic above instead.
   // The take outputs are refreshed every cycle, even without a take.
   // The core must only use the vector and return address with the pulse.
   // The wake-up pulse lasts one cycle per newly set flag.
   // A flag that is already set gives no further wake-up.
   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         edge_sel_reg <= `EDGE_NONE;
         ctrl0_reg    <= 7'h00;
         ctrl1_reg    <= `RESET_BYTE;
         sine_en_reg  <= 1'b0;
         sine_f_reg   <= 1'b0;
         grp0_en_reg  <= 2'h0;
         grp0_f_reg   <= 2'h0;
         grp1_en_reg  <= 2'h0;
         grp1_f_reg   <= 2'h0;
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         AVS_READDATA <= 32'h00000000;
         IRQ_TAKE     <= 1'b0;
         IRQ_VECTOR   <= {PC_W{1'b0}};
         PUSH_PC      <= {PC_W{1'b0}};
         WAKEUP       <= 1'b0;
      end else begin
         pin_meta_reg <= EXT_PIN;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
         ack_pend_reg <= (AVS_READ | AVS_WRITE) & ~ack_pend_reg;
         if (AVS_READ & ~ack_pend_reg) begin
            AVS_READDATA <= rd_data;
         end
         ctrl0_reg  <= ctrl0_next;
         ctrl1_reg  <= ctrl1_next;
         sine_f_reg <= sine_f_next;
         grp0_f_reg <= grp0_f_next;
         grp1_f_reg <= grp1_f_next;
         if (wr_lo) begin
            case (AVS_ADDRESS)
               `ADDR_EDGE_SEL: edge_sel_reg <= AVS_WRITEDATA[1:0];
               `ADDR_CTRL2:    sine_en_reg <= AVS_WRITEDATA[`C2_SINE_EN];
               `ADDR_GRP0:     grp0_en_reg <= {AVS_WRITEDATA[`G_CMPA_EN], AVS_WRITEDATA[`G_PER_EN]};
               `ADDR_GRP1:     grp1_en_reg <= {AVS_WRITEDATA[`G_CMPA_EN], AVS_WRITEDATA[`G_PER_EN]};
               default: ;
            endcase
         end
         // The core pushes PUSH_PC and jumps to IRQ_VECTOR on the IRQ_TAKE pulse.
         IRQ_TAKE   <= take;
         IRQ_VECTOR <= sel_vec[PC_W-1:0];
         PUSH_PC    <= NEXT_PC;
         WAKEUP     <= flag_new;
      end
   end
endmodule // irq_ctrl

// ---- sim/irq_ctrl_chk.sv ----
`timescale 1ns/1ns
module irq_ctrl_chk #(parameter PC_W = 12) (
   input wire            CORE_CLK,
   input wire            RSTN,
   input wire [4:0]      AVS_ADDRESS,
   input wire            AVS_READ,
   input wire            AVS_WRITE,
   input wire [31:0]     AVS_READDATA,
   input wire            AVS_WAITREQUEST,
   input wire            STACK_FULL,
   input wire            TAKE_READY,
   input wire [PC_W-1:0] NEXT_PC,
   input wire            IRQ_TAKE,
   input wire [PC_W-1:0] IRQ_VECTOR,
   input wire [PC_W-1:0] PUSH_PC
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   wire req = AVS_READ || AVS_WRITE;
   property p_take_once; IRQ_TAKE |=> !IRQ_TAKE [*2]; endproperty
   a_take_once: assert property (p_take_once) else $error("take not single");
   property p_stack_hold; IRQ_TAKE |-> !$past(STACK_FULL); endproperty
   a_stack_hold: assert property (p_stack_hold) else $error("take with stack full");
   property p_take_ready; IRQ_TAKE |-> $past(TAKE_READY); endproperty
   a_take_ready: assert property (p_take_ready) else $error("take while core busy");
   property p_push_pc; IRQ_TAKE |-> PUSH_PC == $past(NEXT_PC); endproperty
   a_push_pc: assert property (p_push_pc) else $error("pushed address wrong");
   property p_vec_legal; IRQ_TAKE |-> IRQ_VECTOR inside {[12'h004:12'h020]} && IRQ_VECTOR[1:0] == 2'h0; endproperty
   a_vec_legal: assert property (p_vec_legal) else $error("vector outside table");
   property p_wait_first; $rose(req) |-> AVS_WAITREQUEST; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
   property p_wait_ans; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("answer late");
   property p_upper_zero; AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   c_take: cover property (IRQ_TAKE);
   c_full: cover property (STACK_FULL && TAKE_READY);
   c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule // irq_ctrl_chk
bind irq_ctrl irq_ctrl_chk #(.PC_W(PC_W)) chk_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .STACK_FULL(STACK_FULL), .TAKE_READY(TAKE_READY), .NEXT_PC(NEXT_PC), .IRQ_TAKE(IRQ_TAKE),
   .IRQ_VECTOR(IRQ_VECTOR), .PUSH_PC(PUSH_PC));

// ---- sim/cpu_core_model.sv ----
`timescale 1ns/1ns
module cpu_core_model #(parameter DEPTH = 2) (
   input  wire        CORE_CLK,
   input  wire        RSTN,
   input  wire        IRQ_TAKE,
   input  wire [11:0] PUSH_PC,
   input  wire        ret_req,
   input  wire        slow,
   output wire        STACK_FULL,
   output wire        TAKE_READY,
   output reg  [11:0] NEXT_PC
);
   reg [11:0] stack [0:3];
   reg [1:0]  sp_reg;
   reg        ph_reg;
   assign STACK_FULL = (sp_reg == DEPTH);
   // A slow core accepts only every other cycle.
   assign TAKE_READY = !slow || ph_reg;
   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         sp_reg <= 2'h0;
         ph_reg <= 1'b0;
         NEXT_PC <= 12'h100;
      end else begin
         ph_reg <= !ph_reg;
         if (IRQ_TAKE) begin
            stack[sp_reg] <= PUSH_PC;
            sp_reg <= sp_reg + 2'h1;
            NEXT_PC <= 12'h200;
         end else if (ret_req && sp_reg != 2'h0) begin
            NEXT_PC <= stack[sp_reg - 2'h1];
            sp_reg <= sp_reg - 2'h1;
         end else begin
            NEXT_PC <= NEXT_PC + 12'h1;
         end
      end
   end
endmodule // cpu_core_model

// ---- sim/tb_irq_ctrl.sv ----
`timescale 1ns/1ns
module tb_irq_ctrl;
   reg         clk, rstn, rd, wr, pin, ret_req, slow;
   reg  [4:0]  addr;
   reg  [31:0] wdata;
   reg  [3:0]  be;
   reg  [8:0]  ev;
   reg  [15:0] lf;
   wire [31:0] rdata;
   wire        wait_req, full, ready, take, wake;
   wire [11:0] vec, push_pc, next_pc;
   integer     bad_count, n_checks, i;
   reg  [31:0] exp_rd [$];
   reg  [11:0] exp_tk [$];
   irq_ctrl dut_u (.CORE_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
      .EXT_PIN(pin), .TIMEBASE0_TICK(ev[0]), .TIMEBASE1_TICK(ev[1]), .OVERVOLTAGE_EVENT(ev[2]),
      .UNDERVOLTAGE_EVENT(ev[3]), .SINE_EDGE_EVENT(ev[4]), .STD_PERIOD_MATCH(ev[5]), .STD_COMPARE_A_MATCH(ev[6]),
      .COMPACT_PERIOD_MATCH(ev[7]), .COMPACT_COMPARE_A_MATCH(ev[8]), .STACK_FULL(full), .TAKE_READY(ready),
      .NEXT_PC(next_pc), .IRQ_TAKE(take), .IRQ_VECTOR(vec), .PUSH_PC(push_pc), .WAKEUP(wake));
   cpu_core_model core_u (.CORE_CLK(clk), .RSTN(rstn), .IRQ_TAKE(take), .PUSH_PC(push_pc), .ret_req(ret_req),
      .slow(slow), .STACK_FULL(full), .TAKE_READY(ready), .NEXT_PC(next_pc));
   function [15:0] lfsr(input [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task check(input [31:0] seen, input [31:0] expv, input string what);
      begin
         n_checks = n_checks + 1;
         if (seen !== expv) begin
            bad_count = bad_count + 1;
            $display("Error %0s expected %h seen %h", what, expv, seen);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d errors %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task bus(input w, input [4:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= {24'h0, d};
         rd <= !w;
         wr <= w;
         do @(posedge clk); while (wait_req !== 1'b0);
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task rdc(input [4:0] a, input [7:0] e);
      begin
         exp_rd.push_back({24'h0, e});
         bus(1'b0, a, 8'h00);
      end
   endtask
   task pulse(input integer n, input wk);
      begin
         @(posedge clk);
         ev[n] <= 1'b1;
         @(posedge clk);
         ev[n] <= 1'b0;
         @(posedge clk);
         check(wake, wk, "wakeup");
      end
   endtask
   // Waits for every expected take, then optionally returns from the handler.
   task settle(input r);
      integer k;
      begin
         for (k = 0; k < 40 && exp_tk.size() != 0; k = k + 1)
            @(posedge clk);
         check(exp_tk.size(), 0, "pending");
         if (r) begin
            @(posedge clk);
            ret_req <= 1'b1;
            @(posedge clk);
            ret_req <= 1'b0;
         end
      end
   endtask
   always @(posedge clk) begin
      if (rd && !wait_req)
         check(rdata, exp_rd.pop_front(), "readdata");
      if (take && exp_tk.size() == 0)
         check(1, 0, "take");
      else if (take)
         check(vec, exp_tk.pop_front(), "vector");
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      bad_count = bad_count + 1;
      test_done;
   end
   initial begin
      {rstn, rd, wr, pin, ret_req, slow} = 6'h0;
      addr = 5'h0;
      wdata = 32'h0;
      be = 4'hf;
      ev = 9'h0;
      lf = 16'd9608;
      bad_count = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
         rdc(5'(i * 4), 8'h00);
      bus(1, 5'h00, 8'hff);
      rdc(5'h00, 8'h03);
      bus(1, 5'h04, 8'h7e);
      rdc(5'h04, 8'h7e);
      bus(1, 5'h08, 8'hff);
      rdc(5'h08, 8'hff);
      bus(1, 5'h10, 8'hff);
      rdc(5'h10, 8'h33);
      bus(1, 5'h14, 8'hff);
      rdc(5'h14, 8'h33);
      for (i = 0; i < 6; i = i + 1) begin
         lf = lfsr(lf);
         bus(1, 5'(i * 4), 8'h00);
         bus(1, 5'h0c, lf[7:0]);
         rdc(5'h0c, lf[7:0] & 8'h11);
      end
      bus(1, 5'h0c, 8'h00);
      be <= 4'h0;
      bus(1, 5'h0c, 8'h11);
      be <= 4'hf;
      rdc(5'h0c, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         bus(1, 5'h00, i[7:0]);
         bus(1, 5'h04, 8'h00);
         pin <= 1'b1;
         repeat (6) @(posedge clk);
         rdc(5'h04, {3'h0, i[0], 4'h0});
         bus(1, 5'h04, 8'h00);
         pin <= 1'b0;
         repeat (6) @(posedge clk);
         rdc(5'h04, {3'h0, i[1], 4'h0});
      end
      bus(1, 5'h04, 8'h00);
      pulse(0, 1'b1);
      pulse(0, 1'b0);
      bus(1, 5'h04, 8'h24);
      rdc(5'h04, 8'h24);
      exp_tk.push_back(12'h008);
      bus(1, 5'h04, 8'h25);
      settle(1'b1);
      rdc(5'h04, 8'h04);
      slow <= 1'b1;
      bus(1, 5'h08, 8'h44);
      exp_tk.push_back(12'h00c);
      bus(1, 5'h04, 8'h49);
      settle(1'b1);
      exp_tk.push_back(12'h010);
      bus(1, 5'h04, 8'h09);
      settle(1'b1);
      rdc(5'h08, 8'h04);
      bus(1, 5'h14, 8'h02);
      bus(1, 5'h10, 8'h01);
      pulse(5, 1'b1);
      pulse(8, 1'b1);
      pulse(4, 1'b1);
      pulse(1, 1'b1);
      pulse(2, 1'b1);
      pulse(3, 1'b1);
      pulse(6, 1'b1);
      pulse(7, 1'b1);
      bus(1, 5'h0c, 8'h11);
      bus(1, 5'h08, 8'h33);
      exp_tk.push_back(12'h018);
      bus(1, 5'h04, 8'h01);
      settle(1'b0);
      exp_tk.push_back(12'h01c);
      bus(1, 5'h04, 8'h01);
      settle(1'b0);
      bus(1, 5'h04, 8'h01);
      repeat (8) @(posedge clk);
      rdc(5'h08, 8'h23);
      exp_tk.push_back(12'h020);
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      settle(1'b1);
      rdc(5'h10, 8'h31);
      rdc(5'h14, 8'h32);
      settle(1'b1);
      settle(1'b1);
      test_done;
   end
endmodule // tb_irq_ctrl
